// *** verilog/pps_pkg.sv ***
// Purpose: Shared constants and types for the port power register block
// Assumes: 8-bit register port, 100 MHz MCLK
// Notes: Offsets are the byte addresses seen by the SMBus host engine
`default_nettype none
package pps_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] PPS_ADR_STAT1 = 8'h04;
    localparam logic [7:0] PPS_ADR_GSTAT2 = 8'h0F;
    localparam logic [7:0] PPS_ADR_GSTAT1 = 8'h10;
    localparam logic [7:0] PPS_ADR_GCFG2 = 8'h11;
    localparam logic [7:0] PPS_ADR_GCFG1 = 8'h12;
    localparam logic [7:0] PPS_ADR_GCFG3 = 8'h13;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int PPS_B_ERR = 7;
    localparam int PPS_B_OVLIM = 0;
    localparam int PPS_B_RATION = 7;
    localparam int PPS_B_CC = 4;
    localparam int PPS_B_ENST = 3;
    localparam int PPS_B_MASK = 7;
    localparam int PPS_B_FDIS = 5;
    localparam int PPS_B_OVR = 4;
    localparam int PPS_B_DTIME = 2;
    localparam int PPS_B_AUTO = 2;
    localparam int PPS_B_IGN = 7;
    localparam int PPS_B_RSV = 6;
    localparam int PPS_B_TOOFF = 5;
    localparam int PPS_B_HILOAD = 2;
    // ****************************************
    // Reset values and write masks
    // ****************************************
    localparam logic [7:0] PPS_RST_GCFG2 = 8'h04;
    localparam logic [7:0] PPS_RST_GCFG1 = 8'h00;
    localparam logic [7:0] PPS_RST_GCFG3 = 8'h60;
    localparam logic [7:0] PPS_WMASK_GCFG2 = 8'hBC;
    localparam logic [7:0] PPS_WMASK_GCFG1 = 8'hB4;
    localparam logic [7:0] PPS_WMASK_GCFG3 = 8'hA0;
    // ****************************************
    // Timing and port states
    // ****************************************
    localparam int PPS_CLK_HZ = 100_000_000;
    localparam int PPS_DIS_STEP_MS = 100;
    localparam int PPS_TICK_CYC = PPS_CLK_HZ / 1000;
    localparam logic [16:0] PPS_TICK_MAX = 17'(PPS_TICK_CYC - 1);
    localparam logic [8:0] PPS_DIS_STEP = 9'(PPS_DIS_STEP_MS);
    typedef enum logic [1:0] {PPS_ACTIVE, PPS_DISCH, PPS_ERROR} pps_state_t;
endpackage
`default_nettype wire

// *** verilog/pps_port_if.sv ***
// Purpose: Bundle between the register core and one port engine
// Assumes: Single MCLK domain
// Notes: One instance per port
`timescale 1ns/100ps
`default_nettype none
interface pps_port_if;
    logic ovc;
    logic ration_evt;
    logic cc;
    logic en_pin;
    logic ration_on;
    logic ration_clr;
    logic thermal_shutdown;
    logic ovflag;
    logic err;
    logic err_wr0;
    logic rd_stat;
    logic mask;
    logic fdis;
    logic fdis_rise;
    logic auto_on;
    logic man_load;
    logic ms_tick;
    logic [1:0] dsel;
    logic alert;
    logic switch_on;
    logic disch;
    logic vtest_chk;
    modport core (input ovflag, err, alert, switch_on, disch, vtest_chk,
        output ovc, thermal_shutdown, err_wr0, rd_stat, mask, fdis, fdis_rise, auto_on,
        man_load, ms_tick, dsel, en_pin, cc, ration_evt, ration_on,
        ration_clr);
    modport port (output ovflag, err, alert, switch_on, disch, vtest_chk,
        input ovc, thermal_shutdown, err_wr0, rd_stat, mask, fdis, fdis_rise, auto_on,
        man_load, ms_tick, dsel, en_pin, cc, ration_evt, ration_on,
        ration_clr);
endinterface
`default_nettype wire

// *** verilog/pps_port.sv ***
// Purpose: Per-port error state, alert and discharge timing
// Assumes: Inputs already synchronised; ms_tick is a one-cycle enable
// Notes: Status outputs are registered
`timescale 1ns/100ps
`default_nettype none
module pps_port
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Core side
    pps_port_if.port p
);
    pps_state_t st_q, st_d;
    logic ov_q, ov_d, err_q, err_d, al_q, al_d, ind_q, ind_d;
    logic [8:0] cnt_q, cnt_d;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        // Set wins over the read clear; read clears only a gone fault
        ov_d = p.ovc | (ov_q & ~(p.rd_stat | p.err_wr0));
        err_d = err_q;
        // Event alert follows the ration flag, so it drops when that clears
        ind_d = p.ration_evt & p.ration_on & ~p.ration_clr;
        if (p.ovc) begin
            st_d = PPS_ERROR;
            err_d = 1'b1;
        end else if (p.err_wr0 && st_q == PPS_ERROR) begin
            // Leave only when no fault remains
            err_d = 1'b0;
            st_d = (p.thermal_shutdown) ? PPS_ERROR : PPS_ACTIVE;
            if (p.thermal_shutdown)
                err_d = 1'b1;
        end else if (st_q == PPS_ACTIVE && p.fdis_rise && p.auto_on) begin
            st_d = PPS_DISCH;
            cnt_d = 9'(PPS_DIS_STEP * (9'(p.dsel) + 9'd1));
        end else if (st_q == PPS_DISCH && p.ms_tick) begin
            if (cnt_q <= 9'd1)
                st_d = PPS_ACTIVE;
            cnt_d = cnt_q - 9'd1;
        end
        // Alert filter: masked ports alert only on overcurrent or THERMAL_SHUTDOWN
        if (p.mask)
            al_d = ov_d | p.thermal_shutdown;
        else
            al_d = ov_d | p.thermal_shutdown | ind_d | p.cc;
        // Alert pin is its own path, not a copy of the error bit
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PPS_ACTIVE;
            cnt_q <= 9'h000;
            ov_q <= 1'b0;
            err_q <= 1'b0;
            al_q <= 1'b0;
            ind_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            err_q <= err_d;
            al_q <= al_d;
            ind_q <= ind_d;
        end
    end

    assign p.ovflag = ov_q;
    assign p.err = err_q;
    assign p.alert = al_q;
    // Switch opens in error or forced discharge
    assign p.switch_on = p.en_pin & (st_q == PPS_ACTIVE);
    // Manual load only when automatic discharge is off
    assign p.disch = (st_q == PPS_DISCH) | (~p.auto_on & p.man_load);
    // No post-discharge voltage check without auto discharge
    assign p.vtest_chk = p.auto_on & (st_q == PPS_DISCH) & p.ms_tick
        & (cnt_q == 9'd1);
endmodule
`default_nettype wire

// *** verilog/pps_regs.sv ***
// Purpose: Status and configuration registers of the dual-port power switch
// Assumes: SMBus engine gives one-cycle read and write strobes on MCLK
// Notes: Sensor inputs are asynchronous and synchronised here
//
// Notes on behaviour
// - Port 1 overcurrent sets its flag, alert and the Error state.
// - Read clears overcurrent only once gone; error-bit clear also clears it.
// - Alert pin may change independently of the error bit.
// - Rationing flag sets on delivery; clears on read, reset or disable.
// - Constant-current bit reads 1 while in constant-current limiting.
// - Enable-state bit equals enable pin OR software override.
// - Mask 1 alerts only overcurrent or thermal; mask 0 any event.
// - Forced discharge write opens switch and discharges for set time.
// - Software override is ORed with the enable pin.
// - Discharge time codes give 100 to 400 ms, shared by both ports.
// - Auto discharge off: only manual load bits discharge.
// - Auto discharge on: only forced bits discharge manually.
// - Auto discharge off skips the post-discharge voltage check.
// - Pin-ignore drops the enable pins from the power state.
// - Timeout-disable bit turns SMBus timeout off; resets to 1.
// - High-load bit shows either port above the high_load_indicator threshold.
// - Configuration is kept through Sleep.
// - Error-bit write of 0 rechecks faults before returning to Active.
`timescale 1ns/100ps
`default_nettype none
module pps_regs
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port from the SMBus engine
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Analog sense inputs
    input wire logic [1:0] OVERCURRENT,
    input wire logic [1:0] RATION_DONE,
    input wire logic [1:0] CONST_CURRENT,
    input wire logic [1:0] HIGH_LOAD,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic [1:0] ENABLE_PIN,
    // Rationing and manual load controls from other registers
    input wire logic [1:0] RATION_ON,
    input wire logic [1:0] RATION_CLEAR,
    input wire logic [1:0] MANUAL_DISCHARGE_LOAD,
    // Port outputs
    output logic [1:0] ALERT_N,
    output logic [1:0] SWITCH_ON,
    output logic [1:0] DISCHARGE_ON,
    output logic [1:0] VTEST_CHECK,
    output logic BUS_TIMEOUT_ON
);
    pps_port_if pif[2] ();
    logic [1:0] ovc_s1, ovc_s2, rat_s1, rat_s2, cc_s1, cc_s2;
    logic [1:0] hl_s1, hl_s2, en_s1, en_s2;
    logic tsd_s1, tsd_s2;
    logic [7:0] cfg2_q, cfg2_d, cfg1_q, cfg1_d, cfg3_q, cfg3_d;
    logic [7:0] rd_q, rd_d;
    logic [1:0] rat_q, rat_d, fd_q, en_st, pwr_en;
    logic [16:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [1:0] al_q, sw_q, dis_q, vt_q;
    logic to_q;
    logic [1:0] fd_now;
    logic hit_st1, hit_g2, hit_g1;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two flops on every asynchronous sense input
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ovc_s1 <= 2'h0;
            ovc_s2 <= 2'h0;
            rat_s1 <= 2'h0;
            rat_s2 <= 2'h0;
            cc_s1 <= 2'h0;
            cc_s2 <= 2'h0;
            hl_s1 <= 2'h0;
            hl_s2 <= 2'h0;
            en_s1 <= 2'h0;
            en_s2 <= 2'h0;
            tsd_s1 <= 1'b0;
            tsd_s2 <= 1'b0;
        end else begin
            ovc_s1 <= OVERCURRENT;
            ovc_s2 <= ovc_s1;
            rat_s1 <= RATION_DONE;
            rat_s2 <= rat_s1;
            cc_s1 <= CONST_CURRENT;
            cc_s2 <= cc_s1;
            hl_s1 <= HIGH_LOAD;
            hl_s2 <= hl_s1;
            en_s1 <= ENABLE_PIN;
            en_s2 <= en_s1;
            tsd_s1 <= THERMAL_SHUTDOWN;
            tsd_s2 <= tsd_s1;
        end
    end

    // ****************************************
    // Register write and read
    // ****************************************
    // Decodes for the write path; hit_st1 also feeds the read clear
    assign hit_st1 = (REG_ADDR == PPS_ADR_STAT1);
    assign hit_g2 = (REG_ADDR == PPS_ADR_GCFG2);
    assign hit_g1 = (REG_ADDR == PPS_ADR_GCFG1);
    assign fd_now = {cfg2_q[PPS_B_FDIS], cfg1_q[PPS_B_FDIS]};
    // Status bit is always pin OR override; pin-ignore acts on power only
    assign en_st[0] = en_s2[0] | cfg1_q[PPS_B_OVR];
    assign en_st[1] = en_s2[1] | cfg2_q[PPS_B_OVR];
    assign pwr_en[0] = (en_s2[0] & ~cfg3_q[PPS_B_IGN])
        | cfg1_q[PPS_B_OVR];
    assign pwr_en[1] = (en_s2[1] & ~cfg3_q[PPS_B_IGN])
        | cfg2_q[PPS_B_OVR];

    always_comb begin
        cfg1_d = cfg1_q;
        cfg2_d = cfg2_q;
        cfg3_d = cfg3_q;
        rd_d = rd_q;
        // Config only changes on writes, so it survives Sleep
        if (REG_WR && hit_g1)
            cfg1_d = REG_WDATA & PPS_WMASK_GCFG1;
        if (REG_WR && hit_g2)
            cfg2_d = REG_WDATA & PPS_WMASK_GCFG2;
        if (REG_WR && REG_ADDR == PPS_ADR_GCFG3)
            // Reserved bit held at its fixed value whatever is written
            cfg3_d = (REG_WDATA & PPS_WMASK_GCFG3)
                | (PPS_RST_GCFG3 & ~PPS_WMASK_GCFG3);
        // Rationing: event wins over read clear
        rat_d = rat_s2 | (rat_q & ~RATION_CLEAR & RATION_ON);
        if (REG_RD && REG_ADDR == PPS_ADR_GSTAT1)
            rat_d[0] = rat_s2[0];
        if (REG_RD && REG_ADDR == PPS_ADR_GSTAT2)
            rat_d[1] = rat_s2[1];
        rat_d = rat_d & RATION_ON & ~RATION_CLEAR;
        if (REG_RD) begin
            rd_d = 8'h00;
            unique case (REG_ADDR)
                PPS_ADR_STAT1: begin
                    rd_d[PPS_B_ERR] = pif[0].err;
                    rd_d[PPS_B_OVLIM] = pif[0].ovflag;
                end
                PPS_ADR_GSTAT2: begin
                    rd_d[PPS_B_RATION] = rat_q[1];
                    rd_d[PPS_B_CC] = cc_s2[1];
                    rd_d[PPS_B_ENST] = en_st[1];
                end
                PPS_ADR_GSTAT1: begin
                    rd_d[PPS_B_RATION] = rat_q[0];
                    rd_d[PPS_B_CC] = cc_s2[0];
                    rd_d[PPS_B_ENST] = en_st[0];
                end
                PPS_ADR_GCFG2: rd_d = cfg2_q;
                PPS_ADR_GCFG1: rd_d = cfg1_q;
                PPS_ADR_GCFG3: begin
                    rd_d = cfg3_q;
                    rd_d[PPS_B_HILOAD] = |hl_s2;
                end
                default: rd_d = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Millisecond enable divider
    // ****************************************
    always_comb begin
        tick_d = (tick_cnt_q == PPS_TICK_MAX);
        tick_cnt_d = tick_d ? 17'h00000 : tick_cnt_q + 17'h00001;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg1_q <= PPS_RST_GCFG1;
            cfg2_q <= PPS_RST_GCFG2;
            cfg3_q <= PPS_RST_GCFG3;
            rd_q <= 8'h00;
            rat_q <= 2'h0;
            fd_q <= 2'h0;
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b0;
        end else begin
            cfg1_q <= cfg1_d;
            cfg2_q <= cfg2_d;
            cfg3_q <= cfg3_d;
            rd_q <= rd_d;
            rat_q <= rat_d;
            fd_q <= fd_now;
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ****************************************
    // Port engines
    // ****************************************
    // Both ports share the one discharge time field
    for (genvar i = 0; i < 2; i++) begin : g_port
        assign pif[i].ovc = ovc_s2[i];
        assign pif[i].thermal_shutdown = tsd_s2;
        assign pif[i].cc = cc_s2[i];
        assign pif[i].ration_evt = rat_q[i];
        assign pif[i].ration_on = RATION_ON[i];
        assign pif[i].ration_clr = RATION_CLEAR[i];
        assign pif[i].en_pin = pwr_en[i];
        assign pif[i].ms_tick = tick_q;
        assign pif[i].dsel = cfg2_q[PPS_B_DTIME +: 2];
        assign pif[i].auto_on = cfg1_q[PPS_B_AUTO];
        assign pif[i].man_load = MANUAL_DISCHARGE_LOAD[i];
        assign pif[i].fdis = fd_now[i];
        // Rising edge only: bit stays 1 until the host clears it
        assign pif[i].fdis_rise = fd_now[i] & ~fd_q[i];
        assign pif[i].mask = (i == 0) ? cfg1_q[PPS_B_MASK]
            : cfg2_q[PPS_B_MASK];
        assign pif[i].rd_stat = (i == 0) ? (REG_RD & hit_st1) : 1'b0;
        assign pif[i].err_wr0 = (i == 0) ?
            (REG_WR & hit_st1 & ~REG_WDATA[PPS_B_ERR]) : 1'b0;
        pps_port u_port (
            .clk(MCLK),
            .rst_n(RST_N),
            .p(pif[i].port)
        );
    end

    // Output flops so every pin comes from a register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            al_q <= 2'h3; // Alert flops hold the active-low pin level
            to_q <= 1'b0;
            sw_q <= 2'h0;
            dis_q <= 2'h0;
            vt_q <= 2'h0;
        end else begin
            al_q <= ~{pif[1].alert, pif[0].alert};
            to_q <= ~cfg3_q[PPS_B_TOOFF];
            sw_q <= {pif[1].switch_on, pif[0].switch_on};
            dis_q <= {pif[1].disch, pif[0].disch};
            vt_q <= {pif[1].vtest_chk, pif[0].vtest_chk};
        end
    end

    assign REG_RDATA = rd_q;
    assign ALERT_N = al_q;
    assign SWITCH_ON = sw_q;
    assign DISCHARGE_ON = dis_q;
    assign VTEST_CHECK = vt_q;
    assign BUS_TIMEOUT_ON = to_q;
endmodule
`default_nettype wire

// *** bench/pps_host.sv ***
// Purpose: Register host model driving the block's strobe port
// Assumes: Strobes are launched on the falling edge of mclk
// Notes: Address line, and data line after a write, is left inverted when idle
`timescale 1ns/100ps
`default_nettype none
module pps_host (
    // Clock
    input wire logic mclk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    import pps_pkg::*;
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end
    // One-cycle write; the reserved cfg3 bit is written as it reads
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = (a == PPS_ADR_GCFG3) ? (d | 8'h40) : d;
        reg_wr = 1'h1;
        @(negedge mclk);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // One-cycle read; data is registered, so take it a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge mclk);
        reg_rd = 1'h0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** bench/pps_regs_properties.sv ***
// Purpose: Port-level checks of the register block
// Assumes: Single MCLK domain, RST_N asynchronous active low
// Notes: Config bits are shadowed from writes seen on the port
`timescale 1ns/100ps
`default_nettype none
module pps_regs_properties (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Sense and controls
    input wire logic [1:0] OVERCURRENT,
    input wire logic [1:0] RATION_ON,
    input wire logic [1:0] MANUAL_DISCHARGE_LOAD,
    // Port outputs
    input wire logic [1:0] ALERT_N,
    input wire logic [1:0] SWITCH_ON,
    input wire logic [1:0] DISCHARGE_ON,
    input wire logic [1:0] VTEST_CHECK,
    input wire logic BUS_TIMEOUT_ON
);
    import pps_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic c1_wr, c3_wr, mapped;
    logic [2:0] sh_q, sh_d;
    // *****
    // Shadow of timeout-on, forced bit and auto bit
    // *****
    assign c1_wr = REG_WR && REG_ADDR == PPS_ADR_GCFG1;
    assign c3_wr = REG_WR && REG_ADDR == PPS_ADR_GCFG3;
    assign mapped = REG_ADDR inside {PPS_ADR_STAT1, PPS_ADR_GSTAT2,
        PPS_ADR_GSTAT1, PPS_ADR_GCFG2, PPS_ADR_GCFG1, PPS_ADR_GCFG3};
    // Next shadow value from port writes
    always_comb begin
        sh_d = sh_q;
        if (c1_wr) begin
            sh_d[1:0] = {REG_WDATA[PPS_B_FDIS], REG_WDATA[PPS_B_AUTO]};
        end
        if (c3_wr) begin
            sh_d[2] = ~REG_WDATA[PPS_B_TOOFF];
        end
    end
    // Shadow register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sh_q <= 3'h0;
        end else begin
            sh_q <= sh_d;
        end
    end
    property p_rd_refused;
        REG_RD && !mapped |=> REG_RDATA == 8'h00;
    endproperty
    a_rd_refused: assert property (p_rd_refused)
        else $error("unmapped read not zero");
    property p_rd_hold;
        !REG_RD |=> $stable(REG_RDATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_cfg3_fixed;
        REG_RD && REG_ADDR == PPS_ADR_GCFG3 |=> REG_RDATA[6] && !REG_RDATA[1];
    endproperty
    a_cfg3_fixed: assert property (p_cfg3_fixed)
        else $error("cfg3 fixed bits wrong");
    property p_timeout;
        !c3_wr && $past(!c3_wr) |-> BUS_TIMEOUT_ON == sh_q[2];
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout output not inverse of bit");
    property p_ration_off;
        REG_RD && REG_ADDR == PPS_ADR_GSTAT1 && !RATION_ON[0]
            && $past(!RATION_ON[0]) |=> !REG_RDATA[PPS_B_RATION];
    endproperty
    a_ration_off: assert property (p_ration_off)
        else $error("ration flag set while disabled");
    property p_ovc_alert;
        OVERCURRENT[0] [*4] |-> ##[0:4] !ALERT_N[0];
    endproperty
    a_ovc_alert: assert property (p_ovc_alert)
        else $error("overcurrent without alert");
    property p_fdis_start;
        c1_wr && REG_WDATA[PPS_B_FDIS] && !sh_q[1] && REG_WDATA[PPS_B_AUTO]
            && ALERT_N[0] && SWITCH_ON[0]
            |-> ##[1:4] DISCHARGE_ON[0] && !SWITCH_ON[0];
    endproperty
    a_fdis_start: assert property (p_fdis_start)
        else $error("forced discharge did not start");
    property p_fdis_off;
        c1_wr && !REG_WDATA[PPS_B_AUTO] && !sh_q[0] && !DISCHARGE_ON[0]
            && !MANUAL_DISCHARGE_LOAD[0]
            |=> (!DISCHARGE_ON[0] || $past(MANUAL_DISCHARGE_LOAD[0])) [*3];
    endproperty
    a_fdis_off: assert property (p_fdis_off)
        else $error("discharge with auto off");
    property p_manual;
        !sh_q[0] && $past(!sh_q[0]) && MANUAL_DISCHARGE_LOAD[0]
            |-> ##[0:2] DISCHARGE_ON[0];
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual load ignored");
    property p_vtest;
        VTEST_CHECK[0] |-> sh_q[0] && $past(DISCHARGE_ON[0])
            ##1 !VTEST_CHECK[0];
    endproperty
    a_vtest: assert property (p_vtest)
        else $error("voltage check pulse wrong");
    // Main scenarios reached
    c_fdis: cover property ($rose(DISCHARGE_ON[0]));
    c_alert: cover property ($fell(ALERT_N[0]));
    c_timeout: cover property ($rose(BUS_TIMEOUT_ON));
endmodule
bind pps_regs pps_regs_properties u_props (.MCLK(MCLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OVERCURRENT(OVERCURRENT),
    .RATION_ON(RATION_ON), .MANUAL_DISCHARGE_LOAD(MANUAL_DISCHARGE_LOAD),
    .ALERT_N(ALERT_N), .SWITCH_ON(SWITCH_ON), .DISCHARGE_ON(DISCHARGE_ON),
    .VTEST_CHECK(VTEST_CHECK), .BUS_TIMEOUT_ON(BUS_TIMEOUT_ON));
`default_nettype wire

// *** bench/pps_regs_bench.sv ***
// Purpose: Self-checking bench for the port power register block
// Assumes: Sense inputs settle within eight cycles of synchronising
// Notes: Discharge timing is too long to run out here
`timescale 1ns/100ps
`default_nettype none
module pps_regs_bench;
    import pps_pkg::*;
    logic mclk, rst_n, wr, rd, thermal_shutdown, bto;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] ovc, rdone, cc, hl, en, ron, rclr, mdl, al_n, sw, dis, vt;
    int bad_count, check_count;
    // *****
    // Clock, design and host
    // *****
    initial mclk = 1'h0;
    always #5 mclk = ~mclk;
    pps_regs dut (.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .OVERCURRENT(ovc), .RATION_DONE(rdone), .CONST_CURRENT(cc),
        .HIGH_LOAD(hl), .THERMAL_SHUTDOWN(thermal_shutdown), .ENABLE_PIN(en),
        .RATION_ON(ron), .RATION_CLEAR(rclr), .MANUAL_DISCHARGE_LOAD(mdl),
        .ALERT_N(al_n), .SWITCH_ON(sw), .DISCHARGE_ON(dis),
        .VTEST_CHECK(vt), .BUS_TIMEOUT_ON(bto));
    pps_host h (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    // Compare and count
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        h.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    // *****
    // Test sequence
    // *****
    initial begin
        rst_n = 1'h0;
        {ovc, rdone, cc, hl, en, ron, rclr, mdl, thermal_shutdown} = 17'h00000;
        bad_count = 0;
        check_count = 0;
        w(3);
        rst_n = 1'h1;
        rc(PPS_ADR_GCFG2, PPS_RST_GCFG2);
        rc(PPS_ADR_GCFG1, PPS_RST_GCFG1);
        rc(PPS_ADR_GCFG3, PPS_RST_GCFG3);
        chk("timeout on", 8'h00, {7'h00, bto});
        h.wr(8'h20, 8'hFF);
        rc(8'h20, 8'h00);
        h.wr(PPS_ADR_GCFG1, 8'hD3);
        rc(PPS_ADR_GCFG1, 8'h90);
        h.wr(PPS_ADR_GCFG1, 8'h00);
        // Every discharge time code, read-only bits stay clear
        for (int i = 0; i < 4; i++) begin
            h.wr(PPS_ADR_GCFG2, 8'hF3 | 8'(i << 2));
            rc(PPS_ADR_GCFG2, 8'hB0 | 8'(i << 2));
        end
        h.wr(PPS_ADR_GCFG2, 8'h04);
        h.wr(PPS_ADR_GCFG3, 8'h00);
        rc(PPS_ADR_GCFG3, 8'h40);
        w(2);
        chk("timeout on", 8'h01, {7'h00, bto});
        h.wr(PPS_ADR_GCFG3, 8'h20);
        // Enable pin, override and pin-ignore
        en = 2'h1;
        w(8);
        rc(PPS_ADR_GSTAT1, 8'h08);
        chk("switch", 8'h01, {7'h00, sw[0]});
        h.wr(PPS_ADR_GCFG3, 8'hA0);
        w(8);
        chk("switch", 8'h00, {7'h00, sw[0]});
        rc(PPS_ADR_GSTAT1, 8'h08);
        h.wr(PPS_ADR_GCFG2, 8'h14);
        w(8);
        rc(PPS_ADR_GSTAT2, 8'h08);
        chk("switch", 8'h01, {7'h00, sw[1]});
        h.wr(PPS_ADR_GCFG3, 8'h20);
        h.wr(PPS_ADR_GCFG2, 8'h04);
        // Manual and forced discharge against the auto bit
        en = 2'h3;
        h.wr(PPS_ADR_GCFG1, 8'h20);
        w(8);
        chk("discharge", 8'h00, {7'h00, dis[0]});
        mdl = 2'h3;
        w(4);
        chk("discharge", 8'h03, {6'h00, dis});
        chk("vtest", 8'h00, {6'h00, vt});
        h.wr(PPS_ADR_GCFG1, 8'h04);
        w(4);
        chk("discharge", 8'h00, {6'h00, dis});
        mdl = 2'h0;
        chk("switch", 8'h01, {7'h00, sw[0]});
        h.wr(PPS_ADR_GCFG1, 8'h24);
        w(4);
        chk("disch sw", 8'h02, {6'h00, dis[0], sw[0]});
        h.wr(PPS_ADR_GCFG1, 8'h04);
        // Reset in mid-run ends the long discharge
        rst_n = 1'h0;
        w(3);
        rst_n = 1'h1;
        rc(PPS_ADR_GCFG1, 8'h00);
        // Constant current with port 1 masked, port 2 not
        h.wr(PPS_ADR_GCFG1, 8'h80);
        cc = 2'h3;
        w(8);
        rc(PPS_ADR_GSTAT1, 8'h18);
        rc(PPS_ADR_GSTAT2, 8'h18);
        chk("alert", 8'h01, {6'h00, al_n});
        cc = 2'h0;
        // Overcurrent, refused clear, clear-on-read once gone
        ovc = 2'h1;
        w(8);
        chk("alert", 8'h00, {7'h00, al_n[0]});
        rc(PPS_ADR_STAT1, 8'h81);
        h.wr(PPS_ADR_STAT1, 8'h00);
        rc(PPS_ADR_STAT1, 8'h81);
        ovc = 2'h0;
        w(6);
        rc(PPS_ADR_STAT1, 8'h81);
        rc(PPS_ADR_STAT1, 8'h80);
        h.wr(PPS_ADR_STAT1, 8'h00);
        rc(PPS_ADR_STAT1, 8'h00);
        // Rationing set, read, clear bit and disable
        ron = 2'h3;
        rdone = 2'h3;
        w(6);
        rdone = 2'h0;
        w(4);
        rc(PPS_ADR_GSTAT1, 8'h88);
        rc(PPS_ADR_GSTAT1, 8'h08);
        rclr = 2'h2;
        w(2);
        rclr = 2'h0;
        rc(PPS_ADR_GSTAT2, 8'h08);
        rdone = 2'h2;
        w(6);
        rdone = 2'h0;
        ron = 2'h1;
        w(4);
        rc(PPS_ADR_GSTAT2, 8'h08);
        ron = 2'h0;
        // High-load indicator for every port combination
        for (int i = 0; i < 4; i++) begin
            hl = 2'(i);
            w(6);
            rc(PPS_ADR_GCFG3, (i != 0) ? 8'h64 : 8'h60);
        end
        // Thermal shutdown alerts through the mask
        thermal_shutdown = 1'h1;
        w(8);
        chk("alert", 8'h00, {7'h00, al_n[0]});
        thermal_shutdown = 1'h0;
        end_sim();
    end
endmodule
`default_nettype wire
